// ---- pkg/cpu_sfr_pkg.sv ----
// shared constants and types of the core special-function register block
package cpu_sfr_pkg;

	// --------------------------------------------------------------------
	// special-function register addresses in the data memory
	// --------------------------------------------------------------------
	localparam logic [7:0] ADDR_BANK   = 8'h04;
	localparam logic [7:0] ADDR_ACC    = 8'h05;
	localparam logic [7:0] ADDR_PCL    = 8'h06;
	localparam logic [7:0] ADDR_TABLE_POINTER_LOW   = 8'h07;
	localparam logic [7:0] ADDR_TABLE_READ_HIGH_BYTE   = 8'h08;
	localparam logic [7:0] ADDR_TABLE_POINTER_HIGH   = 8'h09;
	localparam logic [7:0] ADDR_STATUS = 8'h0A;
	localparam logic [7:0] SFR_LAST    = 8'h7F;

	// --------------------------------------------------------------------
	// status fields and reset values
	// --------------------------------------------------------------------
	localparam int         BIT_CARRY   = 0;
	localparam int         BIT_HALF    = 1;
	localparam int         BIT_ZERO    = 2;
	localparam int         BIT_OVF     = 3;
	localparam int         BIT_SLEEP   = 4;
	localparam int         BIT_WDT     = 5;
	localparam logic [1:0] STATUS_TOP  = 2'h0;
	localparam logic [6:0] BANK_TOP    = 7'h00;
	localparam logic [3:0] ARITH_RESET = 4'h0;
	localparam logic [7:0] BYTE_RESET  = 8'h00;

	// flag update masks, bit order {ovf, zero, half, carry}
	localparam logic [3:0] FLAGS_ARITH = 4'hF;
	localparam logic [3:0] FLAGS_ZERO  = 4'h4;
	localparam logic [3:0] FLAGS_CARRY = 4'h1;
	localparam logic [3:0] FLAGS_NONE  = 4'h0;

	typedef enum logic [2:0] {
		OP_ADD  = 3'h0,
		OP_SUB  = 3'h1,
		OP_AND  = 3'h2,
		OP_OR   = 3'h3,
		OP_XOR  = 3'h4,
		OP_RLC  = 3'h5,
		OP_RRC  = 3'h6,
		OP_PASS = 3'h7
	} alu_op_t;

	typedef enum logic [0:0] {
		SEQ_RUN   = 1'h0,
		SEQ_DUMMY = 1'h1
	} seq_t;

endpackage

// ---- core/alu_flag_gen.sv ----
// arithmetic result and flag generation for the special-function register block
`timescale 1ns/10ps
module alu_flag_gen #(
	parameter int WIDTH = 8
) (
	// operation
	input  wire cpu_sfr_pkg::alu_op_t i_op,
	input  wire logic [WIDTH-1:0]     i_a,
	input  wire logic [WIDTH-1:0]     i_b,
	input  wire logic                 i_carry,
	// result and flags
	output logic [WIDTH-1:0]          o_result,
	output logic [3:0]                o_flags,
	output logic [3:0]                o_flag_mask
);
	localparam int NIB = 4;

	if (WIDTH < 2 * NIB) begin : g_bad_width
		$error("alu_flag_gen needs WIDTH of at least 8");
	end

	logic [WIDTH:0]   sum;
	logic [WIDTH-1:0] bop;
	logic [WIDTH-1:0] lsum;
	logic [NIB:0]     low;
	logic             cin;
	logic             c_out;

	always_comb begin
		cin  = (i_op == cpu_sfr_pkg::OP_SUB);
		bop  = cin ? ~i_b : i_b;
		sum  = {1'b0, i_a} + {1'b0, bop} + {{WIDTH{1'b0}}, cin};
		low  = {1'b0, i_a[NIB-1:0]} + {1'b0, bop[NIB-1:0]} + {{NIB{1'b0}}, cin};
		lsum = {1'b0, i_a[WIDTH-2:0]} + {1'b0, bop[WIDTH-2:0]} + {{(WIDTH-1){1'b0}}, cin};
		// subtraction: carry out means no borrow took place
		c_out       = sum[WIDTH]; // RQ10
		o_result    = sum[WIDTH-1:0];
		o_flag_mask = cpu_sfr_pkg::FLAGS_ARITH;
		unique case (i_op)
			cpu_sfr_pkg::OP_ADD, cpu_sfr_pkg::OP_SUB: begin
			end
			cpu_sfr_pkg::OP_AND: begin
				o_result    = i_a & i_b;
				o_flag_mask = cpu_sfr_pkg::FLAGS_ZERO;
			end
			cpu_sfr_pkg::OP_OR: begin
				o_result    = i_a | i_b;
				o_flag_mask = cpu_sfr_pkg::FLAGS_ZERO;
			end
			cpu_sfr_pkg::OP_XOR: begin
				o_result    = i_a ^ i_b;
				o_flag_mask = cpu_sfr_pkg::FLAGS_ZERO;
			end
			cpu_sfr_pkg::OP_RLC: begin
				o_result    = {i_a[WIDTH-2:0], i_carry};
				c_out       = i_a[WIDTH-1]; // RQ10
				o_flag_mask = cpu_sfr_pkg::FLAGS_CARRY;
			end
			cpu_sfr_pkg::OP_RRC: begin
				o_result    = {i_carry, i_a[WIDTH-1:1]};
				c_out       = i_a[0]; // RQ10
				o_flag_mask = cpu_sfr_pkg::FLAGS_CARRY;
			end
			cpu_sfr_pkg::OP_PASS: begin
				o_result    = i_b;
				o_flag_mask = cpu_sfr_pkg::FLAGS_NONE;
			end
		endcase
		o_flags[cpu_sfr_pkg::BIT_CARRY] = c_out;
		o_flags[cpu_sfr_pkg::BIT_HALF]  = low[NIB]; // RQ11
		o_flags[cpu_sfr_pkg::BIT_ZERO]  = (o_result == '0); // RQ12
		o_flags[cpu_sfr_pkg::BIT_OVF]   = lsum[WIDTH-1] ^ sum[WIDTH]; // RQ13
	end

endmodule

// ---- core/cpu_sfr_core.sv ----
// core special-function registers: bank select, accumulator, pcl, table and status
//
// Notes on behaviour
// (RQ1) bank bit zero picks indirect bank
// (RQ2) bank register bits seven to one read zero
// (RQ3) alu results land in the accumulator
// (RQ4) no register to register move, accumulator only
// (RQ5) pcl write jumps within current page
// (RQ6) pcl change inserts one dummy cycle
// (RQ7) table pointers form table address, software writable
// (RQ8) table read: high byte kept, low byte out
// (RQ9) status writes leave system flags untouched
// (RQ10) carry: add carry, no borrow, rotates
// (RQ11) half carry from low nibble
// (RQ12) zero flag follows result equal zero
// (RQ13) overflow: carry into msb xor out
// (RQ14) sleep flag: halt sets, clear or powerup clears
// (RQ15) watchdog flag: timeout sets, clear, halt, powerup clear
// (RQ16) status never pushed by calls or interrupts
// (RQ17) status top bits zero, system flags reset
// (RQ18) direct access always uses bank zero
// (RQ19) reset clears bank except sleeping watchdog reset
// (RQ20) explicit status write beats result flags
`timescale 1ns/10ps
module cpu_sfr_core #(
	parameter int WORD_WIDTH = 16
) (
	// clock and reset
	input  wire logic                    i_clk,
	input  wire logic                    i_rst_b,
	input  wire logic                    i_power_up,
	input  wire logic                    i_keep_bank,
	// special-function register access
	input  wire logic [7:0]              i_sfr_addr,
	input  wire logic                    i_sfr_wr,
	input  wire logic                    i_sfr_rd,
	input  wire logic [7:0]              i_pc_low,
	output logic [7:0]                   o_sfr_rdata,
	// alu operation
	input  wire logic                    i_alu_go,
	input  wire cpu_sfr_pkg::alu_op_t    i_alu_op,
	input  wire logic [7:0]              i_alu_operand,
	input  wire logic                    i_alu_to_sfr,
	output logic [7:0]                   o_acc,
	// system events
	input  wire logic                    i_halt,
	input  wire logic                    i_watchdog_clear_instruction,
	input  wire logic                    i_wdt_timeout,
	output logic [7:0]                   o_status,
	// data memory bank
	input  wire logic [7:0]              i_mem_addr,
	input  wire logic                    i_mem_indirect,
	output logic                         o_bank_sel,
	output logic                         o_mem_bank,
	output logic                         o_mem_is_sfr,
	// program counter
	output logic                         o_pc_jump,
	output logic [7:0]                   o_pc_target_low,
	output logic                         o_dummy_cycle,
	// table read
	input  wire logic                    i_tab_valid,
	input  wire logic [WORD_WIDTH-1:0]   i_tab_word,
	output logic [15:0]                  o_table_addr,
	output logic                         o_tab_low_we,
	output logic [7:0]                   o_tab_low_byte
);
	localparam int BYTE = 8;

	if (WORD_WIDTH < BYTE + 1 || WORD_WIDTH > 2 * BYTE) begin : g_bad_word
		$error("cpu_sfr_core needs WORD_WIDTH between 9 and 16");
	end

	typedef struct packed {
		logic                bank;
		logic [7:0]          acc;
		logic [7:0]          program_counter_low_byte;
		logic [7:0]          table_pointer_low;
		logic [7:0]          table_pointer_high;
		logic [7:0]          table_read_high_byte;
		logic [3:0]          arith;
		logic                wdt_flag;
		logic                sleep_flag;
		cpu_sfr_pkg::seq_t   seq;
		logic                pc_jump;
		logic [7:0]          rdata;
		logic                tab_we;
		logic [7:0]          tab_low;
	} state_t;

	state_t     s;
	state_t     next_s;
	logic [7:0] alu_res;
	logic [3:0] alu_flags;
	logic [3:0] alu_mask;
	logic       wr_any;
	logic [7:0] wr_data;

	// --------------------------------------------------------------------
	// alu
	// --------------------------------------------------------------------
	alu_flag_gen #(
		.WIDTH (BYTE)
	) u_alu (
		.i_op        (i_alu_op),
		.i_a         (s.acc),
		.i_b         (i_alu_operand),
		.i_carry     (s.arith[cpu_sfr_pkg::BIT_CARRY]),
		.o_result    (alu_res),
		.o_flags     (alu_flags),
		.o_flag_mask (alu_mask)
	);

	// writes carry either the accumulator or an alu result; no other
	// register feeds the write path, so a move always goes via the accumulator
	assign wr_any  = i_sfr_wr | (i_alu_go & i_alu_to_sfr);
	assign wr_data = i_alu_go ? alu_res : s.acc; // RQ4

	// --------------------------------------------------------------------
	// next state
	// --------------------------------------------------------------------
	always_comb begin
		next_s         = s;
		next_s.pc_jump = 1'b0;
		next_s.tab_we  = 1'b0;
		next_s.seq     = cpu_sfr_pkg::SEQ_RUN;

		if (i_alu_go) begin
			if (!i_alu_to_sfr) begin
				next_s.acc = alu_res; // RQ3
			end
			next_s.arith = (s.arith & ~alu_mask) | (alu_flags & alu_mask); // RQ10 RQ11 RQ12 RQ13
		end

		// explicit writes come after the flag update so they take effect
		if (wr_any) begin
			unique case (i_sfr_addr)
				cpu_sfr_pkg::ADDR_BANK: begin
					next_s.bank = wr_data[0]; // RQ1
				end
				cpu_sfr_pkg::ADDR_ACC: begin
					next_s.acc = wr_data;
				end
				cpu_sfr_pkg::ADDR_PCL: begin
					next_s.program_counter_low_byte     = wr_data; // RQ5
					next_s.pc_jump = 1'b1;
					next_s.seq     = cpu_sfr_pkg::SEQ_DUMMY; // RQ6
				end
				cpu_sfr_pkg::ADDR_TABLE_POINTER_LOW: begin
					next_s.table_pointer_low = wr_data; // RQ7
				end
				cpu_sfr_pkg::ADDR_TABLE_POINTER_HIGH: begin
					next_s.table_pointer_high = wr_data; // RQ7
				end
				cpu_sfr_pkg::ADDR_STATUS: begin
					next_s.arith = wr_data[3:0]; // RQ9 RQ20
				end
				default: begin
				end
			endcase
		end

		// system flags: a timeout in the same cycle as a clear still sets
		if (i_watchdog_clear_instruction) begin
			next_s.wdt_flag   = 1'b0; // RQ15
			next_s.sleep_flag = 1'b0; // RQ14
		end
		if (i_halt) begin
			next_s.wdt_flag   = 1'b0; // RQ15
			next_s.sleep_flag = 1'b1; // RQ14
		end
		if (i_wdt_timeout) begin
			next_s.wdt_flag = 1'b1; // RQ15
		end

		if (i_tab_valid) begin
			next_s.table_read_high_byte    = BYTE'(i_tab_word >> BYTE); // RQ8
			next_s.tab_low = i_tab_word[BYTE-1:0];
			next_s.tab_we  = 1'b1;
		end

		if (i_sfr_rd) begin
			unique case (i_sfr_addr)
				cpu_sfr_pkg::ADDR_BANK:   next_s.rdata = {cpu_sfr_pkg::BANK_TOP, s.bank}; // RQ2
				cpu_sfr_pkg::ADDR_ACC:    next_s.rdata = s.acc;
				cpu_sfr_pkg::ADDR_PCL:    next_s.rdata = i_pc_low;
				cpu_sfr_pkg::ADDR_TABLE_POINTER_LOW:   next_s.rdata = s.table_pointer_low;
				cpu_sfr_pkg::ADDR_TABLE_POINTER_HIGH:   next_s.rdata = s.table_pointer_high;
				cpu_sfr_pkg::ADDR_TABLE_READ_HIGH_BYTE:   next_s.rdata = s.table_read_high_byte;
				cpu_sfr_pkg::ADDR_STATUS: next_s.rdata = o_status;
				default:                  next_s.rdata = cpu_sfr_pkg::BYTE_RESET;
			endcase
		end

		if (!i_rst_b) begin
			next_s.bank    = i_keep_bank ? s.bank : 1'b0; // RQ19
			next_s.acc     = cpu_sfr_pkg::BYTE_RESET;
			next_s.program_counter_low_byte     = cpu_sfr_pkg::BYTE_RESET;
			next_s.table_pointer_low    = cpu_sfr_pkg::BYTE_RESET;
			next_s.table_pointer_high    = cpu_sfr_pkg::BYTE_RESET;
			next_s.table_read_high_byte    = cpu_sfr_pkg::BYTE_RESET;
			next_s.arith   = cpu_sfr_pkg::ARITH_RESET;
			next_s.seq     = cpu_sfr_pkg::SEQ_RUN;
			next_s.pc_jump = 1'b0;
			next_s.rdata   = cpu_sfr_pkg::BYTE_RESET;
			next_s.tab_we  = 1'b0;
			next_s.tab_low = cpu_sfr_pkg::BYTE_RESET;
			// other resets keep the system flags so software can see the cause
			next_s.wdt_flag   = i_power_up ? 1'b0 : s.wdt_flag; // RQ17
			next_s.sleep_flag = i_power_up ? 1'b0 : s.sleep_flag; // RQ17
		end
	end

	always_ff @(posedge i_clk) begin
		s <= next_s;
	end

	// --------------------------------------------------------------------
	// outputs
	// --------------------------------------------------------------------
	// status is only offered for reads; calls and interrupts never stack it
	assign o_status = {cpu_sfr_pkg::STATUS_TOP, s.wdt_flag, s.sleep_flag, s.arith}; // RQ16 RQ17

	assign o_mem_is_sfr    = (i_mem_addr <= cpu_sfr_pkg::SFR_LAST);
	assign o_mem_bank      = i_mem_indirect & s.bank; // RQ1 RQ18
	assign o_bank_sel      = s.bank;
	assign o_acc           = s.acc;
	assign o_sfr_rdata     = s.rdata;
	assign o_pc_jump       = s.pc_jump;
	assign o_pc_target_low = s.program_counter_low_byte; // RQ5
	assign o_dummy_cycle   = (s.seq == cpu_sfr_pkg::SEQ_DUMMY); // RQ6
	assign o_table_addr    = {s.table_pointer_high, s.table_pointer_low}; // RQ7
	assign o_tab_low_we    = s.tab_we; // RQ8
	assign o_tab_low_byte  = s.tab_low;

	// --------------------------------------------------------------------
	// assertions
	// --------------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);

	logic wr_pcl;
	logic wr_stat;
	assign wr_pcl  = wr_any && i_sfr_addr == cpu_sfr_pkg::ADDR_PCL;
	assign wr_stat = wr_any && i_sfr_addr == cpu_sfr_pkg::ADDR_STATUS;

	a_bank_top_zero: assert property ( // RQ2
		i_sfr_rd && i_sfr_addr == cpu_sfr_pkg::ADDR_BANK |=> o_sfr_rdata[7:1] == 7'h00)
		else $error("bank register upper bits not zero");
	a_indirect_bank: assert property (i_mem_indirect |-> o_mem_bank == o_bank_sel) // RQ1
		else $error("indirect access ignores bank bit");
	a_direct_bank0: assert property (!i_mem_indirect |-> !o_mem_bank) // RQ18
		else $error("direct access left bank zero");
	a_alu_to_acc: assert property ( // RQ3
		i_alu_go && !i_alu_to_sfr && !wr_any |=> o_acc == $past(alu_res))
		else $error("alu result not in accumulator");
	a_pcl_jump: assert property ( // RQ5
		wr_pcl |=> o_pc_jump && o_pc_target_low == $past(wr_data))
		else $error("pcl write did not jump");
	a_dummy_slot: assert property ( // RQ6
		wr_pcl ##1 !wr_pcl |-> o_dummy_cycle ##1 !o_dummy_cycle)
		else $error("dummy cycle not exactly one");
	a_status_sys_keep: assert property ( // RQ9
		wr_stat && !i_halt && !i_watchdog_clear_instruction && !i_wdt_timeout |=> $stable(o_status[5:4]))
		else $error("status write changed system flags");
	a_status_explicit: assert property ( // RQ20
		wr_stat && i_alu_go |=> o_status[3:0] == $past(wr_data[3:0]))
		else $error("result flags beat explicit status write");
	a_zero_flag: assert property ( // RQ12
		i_alu_go && alu_mask[cpu_sfr_pkg::BIT_ZERO] && !wr_stat
		|=> o_status[cpu_sfr_pkg::BIT_ZERO] == ($past(alu_res) == 8'h00))
		else $error("zero flag wrong");
	a_halt_flags: assert property ( // RQ14
		i_halt && !i_watchdog_clear_instruction && !i_wdt_timeout |=> o_status[5:4] == 2'h1)
		else $error("halt flags wrong");
	a_wdt_set: assert property (i_wdt_timeout |=> o_status[cpu_sfr_pkg::BIT_WDT]) // RQ15
		else $error("watchdog timeout not flagged");
	a_status_top: assert property (o_status[7:6] == 2'h0) // RQ17
		else $error("status top bits not zero");
	a_table_read: assert property ( // RQ8
		i_tab_valid |=> o_tab_low_we && o_tab_low_byte == $past(i_tab_word[7:0]))
		else $error("table low byte not delivered");
	a_table_read_high_byte_high: assert property ( // RQ8
		i_tab_valid |=> s.table_read_high_byte == BYTE'($past(i_tab_word) >> BYTE))
		else $error("table high byte not kept");

	// --------------------------------------------------------------------
	// register write and clear instruction checks
	// --------------------------------------------------------------------
	a_bank_write: assert property ( // RQ1
		wr_any && i_sfr_addr == cpu_sfr_pkg::ADDR_BANK |=> o_bank_sel == $past(wr_data[0]))
		else $error("bank bit write lost");
	a_tbl_write: assert property ( // RQ7
		wr_any && i_sfr_addr == cpu_sfr_pkg::ADDR_TABLE_POINTER_LOW |=> o_table_addr[7:0] == $past(wr_data))
		else $error("table pointer write lost");
	a_clr_flags: assert property ( // RQ14 RQ15
		i_watchdog_clear_instruction && !i_halt && !i_wdt_timeout |=> o_status[5:4] == 2'h0)
		else $error("clear instruction left system flags");

	// --------------------------------------------------------------------
	// result flag checks, worked out from the operands; add overflow also reads the result in o_acc
	// --------------------------------------------------------------------
	a_rot_carry: assert property ( // RQ10
		i_alu_go && i_alu_op == cpu_sfr_pkg::OP_RLC && !wr_stat
		|=> o_status[cpu_sfr_pkg::BIT_CARRY] == $past(s.acc[BYTE-1]))
		else $error("left rotate carry wrong");
	a_rrc_carry: assert property ( // RQ10
		i_alu_go && i_alu_op == cpu_sfr_pkg::OP_RRC && !wr_stat
		|=> o_status[cpu_sfr_pkg::BIT_CARRY] == $past(s.acc[0]))
		else $error("right rotate carry wrong");
	a_pass_keep: assert property ( // RQ4
		i_alu_go && i_alu_op == cpu_sfr_pkg::OP_PASS && !wr_stat |=> $stable(o_status[3:0]))
		else $error("move changed arithmetic flags");
	a_sub_carry: assert property ( // RQ10
		i_alu_go && i_alu_op == cpu_sfr_pkg::OP_SUB && !wr_stat
		|=> o_status[cpu_sfr_pkg::BIT_CARRY] == ($past(s.acc) >= $past(i_alu_operand)))
		else $error("subtract carry wrong");
	a_add_carry: assert property ( // RQ10
		i_alu_go && i_alu_op == cpu_sfr_pkg::OP_ADD && !wr_stat
		|=> o_status[cpu_sfr_pkg::BIT_CARRY] == (({1'b0, $past(s.acc)} + {1'b0, $past(i_alu_operand)}) > 9'h0FF))
		else $error("add carry wrong");
	a_add_half: assert property ( // RQ11
		i_alu_go && i_alu_op == cpu_sfr_pkg::OP_ADD && !wr_stat
		|=> o_status[cpu_sfr_pkg::BIT_HALF]
			== (({1'b0, $past(s.acc[3:0])} + {1'b0, $past(i_alu_operand[3:0])}) > 5'h0F))
		else $error("add half carry wrong");
	// signed overflow: equal operand signs giving a result of the other sign
	a_add_ovf: assert property ( // RQ13
		i_alu_go && i_alu_op == cpu_sfr_pkg::OP_ADD && !i_alu_to_sfr && !wr_any
		|=> o_status[cpu_sfr_pkg::BIT_OVF] == ($past(s.acc[BYTE-1]) == $past(i_alu_operand[BYTE-1])
			&& o_acc[BYTE-1] != $past(s.acc[BYTE-1])))
		else $error("add overflow wrong");

	c_pcl_jump: cover property (wr_pcl ##1 o_dummy_cycle);
	c_halt: cover property (i_halt ##1 o_status[cpu_sfr_pkg::BIT_SLEEP]);
	c_table: cover property (i_tab_valid ##1 o_tab_low_we);
	c_timeout_clear: cover property (i_wdt_timeout && i_watchdog_clear_instruction);
	c_status_write: cover property (wr_stat && i_alu_go);

endmodule

// ---- verif/cpu_sfr_core_tb.sv ----
// self-checking testbench for the core special-function register block
`timescale 1ns/10ps
module cpu_sfr_core_tb;

	// ------------------------------------------------------------------
	// design ports
	// ------------------------------------------------------------------
	logic                  i_clk, i_rst_b, i_power_up, i_keep_bank;
	logic [7:0]            i_sfr_addr, i_pc_low, i_alu_operand, i_mem_addr;
	logic                  i_sfr_wr, i_sfr_rd, i_alu_go, i_alu_to_sfr;
	cpu_sfr_pkg::alu_op_t  i_alu_op;
	logic                  i_halt, i_watchdog_clear_instruction, i_wdt_timeout, i_mem_indirect, i_tab_valid;
	logic [15:0]           i_tab_word;
	logic [7:0]            o_sfr_rdata, o_acc, o_status, o_pc_target_low, o_tab_low_byte;
	logic                  o_bank_sel, o_mem_bank, o_mem_is_sfr, o_pc_jump, o_dummy_cycle, o_tab_low_we;
	logic [15:0]           o_table_addr;
	int                    err_count;
	int                    total_checks;
	logic [3:0]            exp_f;
	logic [7:0]            rdat;

	cpu_sfr_core #(.WORD_WIDTH(16)) u_cpu_sfr_core (.i_clk(i_clk), .i_rst_b(i_rst_b),
		.i_power_up(i_power_up), .i_keep_bank(i_keep_bank), .i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr),
		.i_sfr_rd(i_sfr_rd), .i_pc_low(i_pc_low), .o_sfr_rdata(o_sfr_rdata), .i_alu_go(i_alu_go),
		.i_alu_op(i_alu_op), .i_alu_operand(i_alu_operand), .i_alu_to_sfr(i_alu_to_sfr), .o_acc(o_acc),
		.i_halt(i_halt), .i_watchdog_clear_instruction(i_watchdog_clear_instruction), .i_wdt_timeout(i_wdt_timeout), .o_status(o_status),
		.i_mem_addr(i_mem_addr), .i_mem_indirect(i_mem_indirect), .o_bank_sel(o_bank_sel),
		.o_mem_bank(o_mem_bank), .o_mem_is_sfr(o_mem_is_sfr), .o_pc_jump(o_pc_jump),
		.o_pc_target_low(o_pc_target_low), .o_dummy_cycle(o_dummy_cycle), .i_tab_valid(i_tab_valid),
		.i_tab_word(i_tab_word), .o_table_addr(o_table_addr), .o_tab_low_we(o_tab_low_we),
		.o_tab_low_byte(o_tab_low_byte));

	initial begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end

	// ------------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask

	task automatic give_verdict;
		if (err_count == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic do_reset(input logic pu, input logic kb);
		i_rst_b <= 1'b0;
		i_power_up <= pu;
		i_keep_bank <= kb;
		repeat (12) @(posedge i_clk);
		i_rst_b <= 1'b1;
		i_power_up <= 1'b0;
		i_keep_bank <= 1'b0;
		@(posedge i_clk);
		#1;
		exp_f = 4'h0;
	endtask

	// alu operation on acc; with to_sfr the result is steered into the register at addr
	task automatic alu(input cpu_sfr_pkg::alu_op_t op, input logic [7:0] b, input logic to_sfr,
		input logic [7:0] addr);
		i_alu_go <= 1'b1;
		i_alu_op <= op;
		i_alu_operand <= b;
		i_alu_to_sfr <= to_sfr;
		i_sfr_wr <= to_sfr;
		i_sfr_addr <= addr;
		@(posedge i_clk);
		i_alu_go <= 1'b0;
		i_alu_to_sfr <= 1'b0;
		i_sfr_wr <= 1'b0;
		#1;
	endtask

	// a plain write without an alu operation takes its value from acc, so load it first
	task automatic wr(input logic [7:0] addr, input logic [7:0] val);
		alu(cpu_sfr_pkg::OP_PASS, val, 1'b0, 8'h00);
		i_sfr_wr <= 1'b1;
		i_sfr_addr <= addr;
		@(posedge i_clk);
		i_sfr_wr <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [7:0] addr);
		i_sfr_rd <= 1'b1;
		i_sfr_addr <= addr;
		@(posedge i_clk);
		i_sfr_rd <= 1'b0;
		#1;
		rdat = o_sfr_rdata;
	endtask

	task automatic ev(input logic h, input logic c, input logic t);
		i_halt <= h;
		i_watchdog_clear_instruction <= c;
		i_wdt_timeout <= t;
		@(posedge i_clk);
		i_halt <= 1'b0;
		i_watchdog_clear_instruction <= 1'b0;
		i_wdt_timeout <= 1'b0;
		#1;
	endtask

	// ------------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------------
	task automatic arith_case(input cpu_sfr_pkg::alu_op_t op, input logic [7:0] a, input logic [7:0] b);
		logic [8:0] s;
		logic [7:0] r;
		logic [3:0] nf;
		logic [3:0] m;
		s = {1'b0, a} + {1'b0, b};
		m = cpu_sfr_pkg::FLAGS_ARITH;
		nf = 4'h0;
		case (op)
			cpu_sfr_pkg::OP_ADD: begin
				r = s[7:0];
				nf = {((({1'b0, a[6:0]} + {1'b0, b[6:0]}) >> 7) != 0) ^ s[8], 1'b0,
					(({1'b0, a[3:0]} + {1'b0, b[3:0]}) >> 4) != 0, s[8]};
			end
			cpu_sfr_pkg::OP_SUB: begin
				r = a - b;
				nf = {(a[7] ^ b[7]) & (a[7] ^ r[7]), 1'b0, a[3:0] >= b[3:0], a >= b};
			end
			cpu_sfr_pkg::OP_RLC: begin
				r = {a[6:0], exp_f[0]};
				nf[0] = a[7];
				m = cpu_sfr_pkg::FLAGS_CARRY;
			end
			cpu_sfr_pkg::OP_RRC: begin
				r = {exp_f[0], a[7:1]};
				nf[0] = a[0];
				m = cpu_sfr_pkg::FLAGS_CARRY;
			end
			cpu_sfr_pkg::OP_PASS: begin
				r = b;
				m = cpu_sfr_pkg::FLAGS_NONE;
			end
			default: begin
				r = (op == cpu_sfr_pkg::OP_AND) ? (a & b) : (op == cpu_sfr_pkg::OP_OR) ? (a | b) : (a ^ b);
				m = cpu_sfr_pkg::FLAGS_ZERO;
			end
		endcase
		nf[2] = (r == 8'h00);
		exp_f = (exp_f & ~m) | (nf & m);
		alu(cpu_sfr_pkg::OP_PASS, a, 1'b0, 8'h00);
		alu(op, b, 1'b0, 8'h00);
		check(o_acc, r, "alu result in acc");
		check(o_status[3:0], exp_f, "arithmetic flags");
	endtask

	task automatic bank_scn;
		check(o_status, 8'h00, "status after power-on");
		rd(cpu_sfr_pkg::ADDR_BANK);
		check(rdat, 8'h00, "bank reset");
		wr(cpu_sfr_pkg::ADDR_BANK, 8'hFF);
		rd(cpu_sfr_pkg::ADDR_BANK);
		check(rdat, 8'h01, "bank upper bits read zero");
		check(o_bank_sel, 1'b1, "bank bit");
		i_mem_addr <= 8'h80;
		i_mem_indirect <= 1'b1;
		#1;
		check({o_mem_bank, o_mem_is_sfr}, 2'h2, "indirect bank 1");
		i_mem_addr <= 8'h7F;
		i_mem_indirect <= 1'b0;
		#1;
		check({o_mem_bank, o_mem_is_sfr}, 2'h1, "direct bank 0");
	endtask

	task automatic status_scn;
		ev(1'b0, 1'b0, 1'b1);
		check(o_status[5:4], 2'h2, "timeout sets flag");
		ev(1'b1, 1'b0, 1'b0);
		check(o_status[5:4], 2'h1, "halt sets sleep, clears timeout");
		ev(1'b0, 1'b0, 1'b1);
		wr(cpu_sfr_pkg::ADDR_STATUS, 8'h00);
		check(o_status, 8'h30, "write keeps system flags");
		wr(cpu_sfr_pkg::ADDR_STATUS, 8'hFF);
		check(o_status, 8'h3F, "write sets arithmetic flags");
		alu(cpu_sfr_pkg::OP_ADD, 8'h01, 1'b1, cpu_sfr_pkg::ADDR_STATUS);
		check(o_status, 8'h30, "explicit write wins over flags");
		check(o_acc, 8'hFF, "acc untouched by sfr result");
		ev(1'b0, 1'b1, 1'b0);
		check(o_status[5:4], 2'h0, "clear instruction");
		ev(1'b0, 1'b1, 1'b1);
		check(o_status[5:4], 2'h2, "timeout beats clear");
	endtask

	task automatic pcl_scn;
		i_pc_low <= 8'h33;
		rd(cpu_sfr_pkg::ADDR_PCL);
		check(rdat, 8'h33, "pcl read");
		wr(cpu_sfr_pkg::ADDR_PCL, 8'h5A);
		check({o_pc_jump, o_dummy_cycle, o_pc_target_low}, 10'h35A, "jump and dummy");
		@(posedge i_clk);
		#1;
		check({o_pc_jump, o_dummy_cycle}, 2'h0, "single dummy cycle");
	endtask

	task automatic table_scn;
		wr(cpu_sfr_pkg::ADDR_TABLE_POINTER_LOW, 8'h12);
		wr(cpu_sfr_pkg::ADDR_TABLE_POINTER_HIGH, 8'h34);
		check(o_table_addr, 16'h3412, "table address");
		i_tab_valid <= 1'b1;
		i_tab_word <= 16'hABCD;
		@(posedge i_clk);
		i_tab_valid <= 1'b0;
		#1;
		check({o_tab_low_we, o_tab_low_byte}, 9'h1CD, "low byte out");
		wr(cpu_sfr_pkg::ADDR_TABLE_READ_HIGH_BYTE, 8'h00);
		rd(cpu_sfr_pkg::ADDR_TABLE_READ_HIGH_BYTE);
		check(rdat, 8'hAB, "high byte kept");
		rd(8'h0B);
		check(rdat, 8'h00, "unmapped read");
	endtask

	task automatic reset_scn;
		wr(cpu_sfr_pkg::ADDR_BANK, 8'h01);
		ev(1'b1, 1'b0, 1'b1);
		do_reset(1'b0, 1'b1);
		check(o_bank_sel, 1'b1, "bank kept on sleeping watchdog reset");
		check(o_status, 8'h30, "system flags kept");
		do_reset(1'b0, 1'b0);
		check(o_bank_sel, 1'b0, "bank cleared by reset");
		do_reset(1'b1, 1'b0);
		check(o_status, 8'h00, "power-up clears flags");
	endtask

	// ------------------------------------------------------------------
	// main sequence and hang guard
	// ------------------------------------------------------------------
	initial begin
		{i_rst_b, i_sfr_wr, i_sfr_rd, i_alu_go, i_alu_to_sfr, i_halt, i_watchdog_clear_instruction} = 7'h00;
		{i_wdt_timeout, i_mem_indirect, i_tab_valid, i_keep_bank} = 4'h0;
		{i_sfr_addr, i_pc_low, i_alu_operand, i_mem_addr, i_tab_word} = 48'h0;
		i_power_up = 1'b1;
		i_alu_op = cpu_sfr_pkg::OP_PASS;
		err_count = 0;
		total_checks = 0;
		do_reset(1'b1, 1'b0);
		bank_scn();
		arith_case(cpu_sfr_pkg::OP_ADD, 8'h7F, 8'h01);
		arith_case(cpu_sfr_pkg::OP_ADD, 8'hFF, 8'h01);
		arith_case(cpu_sfr_pkg::OP_SUB, 8'h05, 8'h05);
		arith_case(cpu_sfr_pkg::OP_SUB, 8'h80, 8'h01);
		arith_case(cpu_sfr_pkg::OP_SUB, 8'h01, 8'h02);
		arith_case(cpu_sfr_pkg::OP_AND, 8'hF0, 8'h0F);
		arith_case(cpu_sfr_pkg::OP_OR, 8'h00, 8'h01);
		arith_case(cpu_sfr_pkg::OP_XOR, 8'hAA, 8'hAA);
		arith_case(cpu_sfr_pkg::OP_RLC, 8'h81, 8'h00);
		arith_case(cpu_sfr_pkg::OP_RRC, 8'h02, 8'h00);
		arith_case(cpu_sfr_pkg::OP_PASS, 8'h00, 8'h5A);
		status_scn();
		pcl_scn();
		table_scn();
		reset_scn();
		give_verdict();
	end

	initial begin
		repeat (5000) @(posedge i_clk);
		err_count++;
		give_verdict();
	end

endmodule
